// *** csw_pkg.sv ***
// constants for the clock switch sequencer
package csw_pkg;

    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [11:0] ADDR_REQUEST = 12'h000;
    localparam logic [11:0] ADDR_CURRENT = 12'h004;
    localparam logic [11:0] ADDR_CTRL = 12'h008;
    localparam logic [11:0] ADDR_FLAGS = 12'h00C;
    localparam logic [11:0] ADDR_IRQEN = 12'h010;

    // ************************************************************
    // source codes
    // ************************************************************
    localparam logic [2:0] SRC_EXT = 3'h0;
    localparam logic [2:0] SRC_FAST = 3'h1;
    localparam logic [2:0] SRC_SLOW = 3'h2;
    localparam logic [2:0] SRC_SEC = 3'h3;
    localparam logic [2:0] SRC_EXT_PLL = 3'h4;
    localparam logic [2:0] SRC_FAST_PLL = 3'h5;
    localparam int NUM_SRC = 6;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int REQ_DIV_LSB = 4;
    localparam int CTRL_HOLD_BIT = 0;
    localparam int CTRL_SLEEP_BIT = 1;
    localparam int CTRL_REDUCED_CPU_DUTY_MODE_BIT = 2;
    localparam int CTRL_NEW_SOURCE_READY_BIT = 3;
    localparam int CTRL_OSCILLATOR_READY_BIT = 4;
    localparam int FLAG_DONE_BIT = 0;
    localparam logic [2:0] RST_SOURCE = 3'h1;
    localparam logic [3:0] RST_DIVIDER = 4'h0;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int SWAP_CYCLES = 2;
    localparam int RELOCK_CYCLES = 8;

    typedef enum logic [2:0] {
        CSW_IDLE,
        CSW_WAIT,
        CSW_RELOCK,
        CSW_GATE,
        CSW_SLEEP
    } csw_state_t;

endpackage : csw_pkg

// *** csw_sequencer.sv ***
// clock switch sequencer with apb registers and glitch-free select
// Notes on behaviour
// - six selectable system clock sources
// - keep old clock until new ready
// - running or same source ready at once
// - ready sets ready bit and done flag
// - done flag with enable raises interrupt
// - hold clear switches on ready
// - hold set suspends switch on old clock
// - writing current code back abandons switch
// - reduced_cpu_duty_mode mode switch on next cycle
// - divider change same sequence, needs hold clear
// - current fields change only at switch
// - ready bit cleared when switch completes
// - pll input fixed by request, kept by current
// - pll input change halts system during relock
// - sleep before switch suspends switch
// - wake hold clear resumes on old clock, switches once new ready
// - wake hold set re-requests new source
`timescale 1ns/1ps
module csw_sequencer #(
    parameter int RELOCK = csw_pkg::RELOCK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] osc_ready,
    input wire logic wake,
    output logic [5:0] osc_enable,
    output logic [5:0] osc_select,
    output logic [3:0] sys_divider,
    output logic sys_halt,
    output logic switch_irq
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [2:0] requested_source_sel_q;
    logic [3:0] requested_divider_sel_q;
    logic [2:0] current_source_q;
    logic [3:0] current_divider_q;
    logic switch_hold_q;
    logic sleep_q;
    logic reduced_cpu_duty_mode_q;
    logic new_source_ready_q;
    logic oscillator_ready_q;
    logic switch_done_flag_q;
    logic switch_done_irq_enable_q;
    logic [2:0] pll_input_q;
    logic [3:0] count_q;
    csw_pkg::csw_state_t state_q;
    logic wr;
    logic pending;
    logic new_ready;
    logic is_pll;
    logic cur_pll;
    logic pll_change;
    logic do_switch;
    logic set_done;
    logic abandon;

    assign wr = psel && penable && pwrite;
    assign pending = (requested_source_sel_q != current_source_q) ||
                     (requested_divider_sel_q != current_divider_q);
    assign new_ready = osc_ready[requested_source_sel_q] ||
                       (requested_source_sel_q == current_source_q);
    assign is_pll = requested_source_sel_q == csw_pkg::SRC_EXT_PLL ||
                    requested_source_sel_q == csw_pkg::SRC_FAST_PLL;
    assign cur_pll = current_source_q == csw_pkg::SRC_EXT_PLL ||
                     current_source_q == csw_pkg::SRC_FAST_PLL;
    assign pll_change = is_pll && cur_pll &&
                        requested_source_sel_q != current_source_q;
    // abandon by writing current code back
    assign abandon = wr && paddr == csw_pkg::ADDR_REQUEST &&
                     pwdata[2:0] == current_source_q;
    // switch when ready and hold clear
    // hold set keeps the old clock
    // reduced_cpu_duty_mode does not delay the switch
    // divider change needs hold clear too
    assign do_switch = (state_q == csw_pkg::CSW_WAIT && new_ready &&
                        !switch_hold_q && !sleep_q && !pll_change) ||
                       (state_q == csw_pkg::CSW_RELOCK &&
                        count_q == 4'(RELOCK - 1));
    // flag set on wake with hold clear
    assign set_done = (state_q == csw_pkg::CSW_WAIT && new_ready &&
                       !new_source_ready_q && !sleep_q) ||
                      (state_q == csw_pkg::CSW_SLEEP && wake &&
                       !switch_hold_q && pending);

    // ************************************************************
    // apb slave
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            requested_source_sel_q <= csw_pkg::RST_SOURCE;
            requested_divider_sel_q <= csw_pkg::RST_DIVIDER;
            switch_hold_q <= 1'b0;
            reduced_cpu_duty_mode_q <= 1'b0;
            switch_done_irq_enable_q <= 1'b0;
        end
        else if (wr)
        begin
            unique case (paddr)
                csw_pkg::ADDR_REQUEST:
                begin
                    if (pwdata[2:0] < 3'(csw_pkg::NUM_SRC))
                    begin
                        requested_source_sel_q <= pwdata[2:0];
                    end
                    requested_divider_sel_q <=
                        pwdata[csw_pkg::REQ_DIV_LSB +: 4];
                end
                csw_pkg::ADDR_CTRL:
                begin
                    switch_hold_q <= pwdata[csw_pkg::CTRL_HOLD_BIT];
                    reduced_cpu_duty_mode_q <=
                        pwdata[csw_pkg::CTRL_REDUCED_CPU_DUTY_MODE_BIT];
                end
                csw_pkg::ADDR_IRQEN:
                begin
                    switch_done_irq_enable_q <= pwdata[0];
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable &&
                       paddr != csw_pkg::ADDR_REQUEST &&
                       paddr != csw_pkg::ADDR_CURRENT &&
                       paddr != csw_pkg::ADDR_CTRL &&
                       paddr != csw_pkg::ADDR_FLAGS &&
                       paddr != csw_pkg::ADDR_IRQEN;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                unique case (paddr)
                    csw_pkg::ADDR_REQUEST:
                        prdata <= 32'({requested_divider_sel_q, 1'b0,
                                       requested_source_sel_q});
                    csw_pkg::ADDR_CURRENT:
                        prdata <= 32'({current_divider_q, 1'b0,
                                       current_source_q});
                    csw_pkg::ADDR_CTRL:
                        prdata <= 32'({oscillator_ready_q,
                                       new_source_ready_q,
                                       reduced_cpu_duty_mode_q,
                                       sleep_q, switch_hold_q});
                    csw_pkg::ADDR_FLAGS:
                        prdata <= 32'(switch_done_flag_q);
                    csw_pkg::ADDR_IRQEN:
                        prdata <= 32'(switch_done_irq_enable_q);
                    default:
                        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // switch sequencer
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= csw_pkg::CSW_IDLE;
            count_q <= 4'h0;
            sleep_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                csw_pkg::CSW_IDLE:
                begin
                    // wait on old clock for new source
                    if (pending)
                    begin
                        state_q <= csw_pkg::CSW_WAIT;
                    end
                    if (wr && paddr == csw_pkg::ADDR_CTRL &&
                        pwdata[csw_pkg::CTRL_SLEEP_BIT])
                    begin
                        sleep_q <= 1'b1;
                        state_q <= csw_pkg::CSW_SLEEP;
                    end
                end
                csw_pkg::CSW_WAIT:
                begin
                    if (wr && paddr == csw_pkg::ADDR_CTRL &&
                        pwdata[csw_pkg::CTRL_SLEEP_BIT])
                    begin
                        sleep_q <= 1'b1;
                        state_q <= csw_pkg::CSW_SLEEP;
                    end
                    else if (abandon || !pending)
                    begin
                        state_q <= csw_pkg::CSW_IDLE;
                    end
                    else if (pll_change && new_ready && !switch_hold_q)
                    begin
                        count_q <= 4'h0;
                        state_q <= csw_pkg::CSW_RELOCK;
                    end
                    else if (do_switch)
                    begin
                        count_q <= 4'h0;
                        state_q <= csw_pkg::CSW_GATE;
                    end
                end
                csw_pkg::CSW_RELOCK:
                begin
                    count_q <= count_q + 4'h1;
                    if (do_switch)
                    begin
                        count_q <= 4'h0;
                        state_q <= csw_pkg::CSW_GATE;
                    end
                end
                csw_pkg::CSW_GATE:
                begin
                    count_q <= count_q + 4'h1;
                    if (count_q == 4'(csw_pkg::SWAP_CYCLES - 1))
                    begin
                        state_q <= csw_pkg::CSW_IDLE;
                    end
                end
                csw_pkg::CSW_SLEEP:
                begin
                    // hold set wakes old, requests again
                    // woken source must be ready before the swap
                    if (wake)
                    begin
                        sleep_q <= 1'b0;
                        state_q <= (pending && !switch_hold_q) ?
                                   csw_pkg::CSW_WAIT : csw_pkg::CSW_IDLE;
                        count_q <= 4'h0;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // current selection and status
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            current_source_q <= csw_pkg::RST_SOURCE;
            current_divider_q <= csw_pkg::RST_DIVIDER;
            pll_input_q <= csw_pkg::SRC_FAST;
            oscillator_ready_q <= 1'b1;
        end
        else if (state_q == csw_pkg::CSW_GATE &&
                 count_q == 4'(csw_pkg::SWAP_CYCLES - 1))
        begin
            current_source_q <= requested_source_sel_q;
            current_divider_q <= requested_divider_sel_q;
            oscillator_ready_q <= 1'b1;
        end
        else if (state_q == csw_pkg::CSW_WAIT && pending)
        begin
            oscillator_ready_q <= 1'b0;
            if (is_pll && !cur_pll)
            begin
                pll_input_q <= requested_source_sel_q;
            end
        end
        else if (state_q == csw_pkg::CSW_RELOCK)
        begin
            pll_input_q <= requested_source_sel_q;
        end
        else if (state_q == csw_pkg::CSW_IDLE && cur_pll)
        begin
            pll_input_q <= current_source_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            new_source_ready_q <= 1'b0;
        end
        else if (set_done)
        begin
            new_source_ready_q <= 1'b1;
        end
        else if (state_q == csw_pkg::CSW_IDLE || abandon)
        begin
            new_source_ready_q <= 1'b0;
        end
    end

    // set wins over software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            switch_done_flag_q <= 1'b0;
        end
        else if (set_done)
        begin
            switch_done_flag_q <= 1'b1;
        end
        else if (wr && paddr == csw_pkg::ADDR_FLAGS &&
                 pwdata[csw_pkg::FLAG_DONE_BIT])
        begin
            switch_done_flag_q <= 1'b0;
        end
    end

    // ************************************************************
    // clock source outputs
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < csw_pkg::NUM_SRC; g++)
        begin : g_src
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    osc_enable[g] <= (3'(g) == csw_pkg::RST_SOURCE);
                    osc_select[g] <= (3'(g) == csw_pkg::RST_SOURCE);
                end
                else
                begin
                    osc_enable[g] <= (3'(g) == current_source_q) ||
                        (3'(g) == requested_source_sel_q && !sleep_q) ||
                        (3'(g) == pll_input_q);
                    // no select during the gate gap
                    osc_select[g] <= (state_q != csw_pkg::CSW_GATE) &&
                        (3'(g) == current_source_q);
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_divider <= csw_pkg::RST_DIVIDER;
            sys_halt <= 1'b0;
            switch_irq <= 1'b0;
        end
        else
        begin
            sys_divider <= current_divider_q;
            sys_halt <= state_q == csw_pkg::CSW_RELOCK ||
                        state_q == csw_pkg::CSW_SLEEP;
            switch_irq <= switch_done_flag_q && switch_done_irq_enable_q;
        end
    end

endmodule : csw_sequencer

// *** csw_monitor.sv ***
// port checks for the clock switch sequencer
`timescale 1ns/1ps
module csw_monitor #(
    parameter int RELOCK = csw_pkg::RELOCK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] osc_ready,
    input wire logic [5:0] osc_enable,
    input wire logic [5:0] osc_select,
    input wire logic [3:0] sys_divider,
    input wire logic sys_halt
);
    // ****
    // bus phases
    // ****
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence setup_phase;
        psel && !penable;
    endsequence
    sequence access_done;
        psel && penable && pready;
    endsequence

    // ****
    // assertions
    // ****
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_ready_follows: assert property (setup_phase |=> access_done)
        else $error("no ready in access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_sel_onehot: assert property ($onehot0(osc_select))
        else $error("select not one-hot");
    a_sel_gap_first: assert property (
        $changed(osc_select) && $past(osc_select) != 6'h00
        |-> osc_select == 6'h00) else $error("select without gap");
    a_sel_only_ready: assert property (
        $changed(osc_select) && osc_select != 6'h00
        |-> (osc_select & ~osc_ready) == 6'h00)
        else $error("selected source not ready");
    a_sel_is_enabled: assert property (
        (osc_select & ~osc_enable) == 6'h00)
        else $error("selected source not enabled");
    a_gap_short: assert property (
        osc_select == 6'h00 |-> ##[1:100] osc_select != 6'h00)
        else $error("clock gap too long");
    a_halt_ends: assert property ($rose(sys_halt) |-> ##[1:100] !sys_halt)
        else $error("halt does not end");
    a_div_kept: assert property (
        access_done and pwrite |=> $stable(sys_divider))
        else $error("divider changed at write");
endmodule : csw_monitor

bind csw_sequencer csw_monitor #(.RELOCK(RELOCK)) mon (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .osc_ready(osc_ready),
    .osc_enable(osc_enable), .osc_select(osc_select),
    .sys_divider(sys_divider), .sys_halt(sys_halt));

// *** csw_osc_model.sv ***
// oscillator bank: ready some cycles after enable
`timescale 1ns/1ps
module csw_osc_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [5:0] osc_enable,
    input wire logic slow,
    output logic [5:0] osc_ready
);
    logic [23:0] cnt_q;

    // startup counters, cleared when a source stops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 24'h0;
        else
            for (int i = 0; i < 6; i++)
            begin
                if (!osc_enable[i])
                    cnt_q[4*i +: 4] <= 4'h0;
                else if (cnt_q[4*i +: 4] != 4'hF)
                    cnt_q[4*i +: 4] <= cnt_q[4*i +: 4] + 4'h1;
            end
    end

    always_comb
    begin
        for (int i = 0; i < 6; i++)
            osc_ready[i] = cnt_q[4*i +: 4] >= (slow ? 4'hC : 4'h3);
    end
endmodule : csw_osc_model

// *** tb.sv ***
// self-checking bench for the clock switch sequencer
`timescale 1ns/1ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, wake, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, sys_halt, switch_irq;
    logic halt_seen = 1'b0;
    logic [5:0] osc_ready, osc_enable, osc_select;
    logic [3:0] sys_divider, div;
    logic [64:0] exp_q[$];
    int bad_count, cmp_count, seed;

    csw_sequencer #(.RELOCK(2)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_ready(osc_ready), .wake(wake),
        .osc_enable(osc_enable), .osc_select(osc_select),
        .sys_divider(sys_divider), .sys_halt(sys_halt),
        .switch_irq(switch_irq));
    csw_osc_model osc (.pclk(pclk), .presetn(presetn),
        .osc_enable(osc_enable), .slow(slow), .osc_ready(osc_ready));

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk)
        if (sys_halt === 1'b1)
            halt_seen <= 1'b1;

    // ****
    // tasks
    // ****
    task automatic summarize;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic miss(input string m);
        bad_count++;
        $display("MISMATCH %0t %s", $time, m);
    endtask : miss

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
            miss($sformatf("port got %h exp %h", got, exp));
    endtask : chk

    task automatic cmp_rd(input logic [64:0] e);
        cmp_count++;
        if (((prdata ^ e[31:0]) & e[63:32]) !== 32'h0 || pslverr !== e[64])
            miss($sformatf("read %h exp %h at %h", prdata, e[31:0], paddr));
    endtask : cmp_rd

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] m, input logic e);
        int k;
        exp_q.push_back({e, m, d});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            miss("no ready");
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] m);
        apb(1'b0, a, d, m, 1'b0);
    endtask : rd

    function automatic logic [31:0] req(input logic [2:0] s,
        input logic [3:0] d);
        return {24'h0, d, 1'b0, s};
    endfunction : req

    task automatic wait_sw(input logic [2:0] s, input logic [3:0] d);
        int k;
        k = 0;
        while ({osc_select, sys_divider} !== {6'h01 << s, d} && k < 200)
        begin
            @(posedge pclk);
            k++;
        end
        if (k >= 200)
        begin
            miss("switch did not complete");
            summarize();
        end
    endtask : wait_sw

    task automatic wake_up;
        wake <= 1'b1;
        @(posedge pclk);
        wake <= 1'b0;
    endtask : wake_up

    always @(posedge pclk)
        if (psel && penable && pready === 1'b1)
        begin
            if (exp_q.size() == 0)
                miss("unexpected transfer");
            else
                cmp_rd(exp_q.pop_front());
        end

    // ****
    // main sequence
    // ****
    initial
    begin
        {psel, penable, pwrite, wake, slow} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        presetn = 1'b0;
        seed = 32'h08982028;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(csw_pkg::ADDR_CURRENT, 32'h1, 32'hFF);
        chk({26'h0, osc_select}, 32'h2);
        apb(1'b0, 12'h014, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, 12'h014, 32'h5, 32'h0, 1'b1);
        wr(csw_pkg::ADDR_IRQEN, 32'h1);
        $display("test reset done");
        for (int s = 0; s < csw_pkg::NUM_SRC; s++)
        begin
            div = 4'($random(seed));
            wr(csw_pkg::ADDR_REQUEST, req(3'(s), div));
            wait_sw(3'(s), div);
            rd(csw_pkg::ADDR_CURRENT, req(3'(s), div), 32'hFF);
            rd(csw_pkg::ADDR_CTRL, 32'h10, 32'h18);
            chk({31'h0, switch_irq}, 32'h1);
            rd(csw_pkg::ADDR_FLAGS, 32'h1, 32'h1);
            wr(csw_pkg::ADDR_FLAGS, 32'h1);
        end
        chk({31'h0, halt_seen}, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, switch_irq}, 32'h0);
        chk({26'h0, osc_enable}, 32'h20);
        $display("test sources done");
        wr(csw_pkg::ADDR_CTRL, 32'h1);
        wr(csw_pkg::ADDR_REQUEST, req(3'h5, ~div));
        repeat (10) @(posedge pclk);
        chk({28'h0, sys_divider}, {28'h0, div});
        rd(csw_pkg::ADDR_CTRL, 32'h9, 32'h9);
        wr(csw_pkg::ADDR_CTRL, 32'h0);
        wait_sw(3'h5, ~div);
        wr(csw_pkg::ADDR_CTRL, 32'h1);
        slow <= 1'b1;
        wr(csw_pkg::ADDR_REQUEST, req(3'h2, 4'h3));
        repeat (20) @(posedge pclk);
        rd(csw_pkg::ADDR_CTRL, 32'h9, 32'h9);
        wr(csw_pkg::ADDR_REQUEST, req(3'h5, ~div));
        wr(csw_pkg::ADDR_CTRL, 32'h0);
        repeat (20) @(posedge pclk);
        chk({26'h0, osc_select}, 32'h20);
        $display("test hold done");
        wr(csw_pkg::ADDR_FLAGS, 32'h1);
        wr(csw_pkg::ADDR_REQUEST, req(3'h0, 4'h1));
        wr(csw_pkg::ADDR_CTRL, 32'h2);
        repeat (15) @(posedge pclk);
        chk({30'h0, sys_halt, osc_select === 6'h01}, 32'h2);
        wake_up();
        wait_sw(3'h0, 4'h1);
        rd(csw_pkg::ADDR_FLAGS, 32'h1, 32'h1);
        wr(csw_pkg::ADDR_CTRL, 32'h1);
        wr(csw_pkg::ADDR_REQUEST, req(3'h3, 4'h2));
        wr(csw_pkg::ADDR_CTRL, 32'h3);
        repeat (5) @(posedge pclk);
        wake_up();
        repeat (4) @(posedge pclk);
        chk({26'h0, osc_select}, 32'h1);
        rd(csw_pkg::ADDR_CTRL, 32'h1, 32'h3);
        wr(csw_pkg::ADDR_CTRL, 32'h0);
        wait_sw(3'h3, 4'h2);
        $display("test sleep done");
        slow <= 1'b0;
        wr(csw_pkg::ADDR_CTRL, 32'h4);
        wr(csw_pkg::ADDR_REQUEST, req(3'h1, 4'h0));
        wait_sw(3'h1, 4'h0);
        rd(csw_pkg::ADDR_CTRL, 32'h4, 32'h4);
        $display("test reduced_cpu_duty_mode done");
        summarize();
    end
endmodule : tb
